// *** src/pwrseq_pkg.sv ***
package pwrseq_pkg;
	// clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int DEGLITCH_US = 100;
	localparam int DEGLITCH_CYC = (CLK_HZ / 1_000_000) * DEGLITCH_US;
	localparam int SPACING_STEP_MS = 1;
	localparam int MS_CYC = (CLK_HZ / 1000) * SPACING_STEP_MS;
	localparam int RELEASE_STEP_MS = 5;
	localparam int RELEASE_STEP_CYC = (CLK_HZ / 1000) * RELEASE_STEP_MS;
	localparam int TMR_W = 24;

	// sizes
	localparam int NUM_RAILS = 6;
	localparam int NUM_SLOTS = 6;
	localparam int ADDR_W = 8;

	// register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_SLEEP_CTRL = 8'h04;
	localparam logic [7:0] OFS_FAULT = 8'h08;
	localparam logic [7:0] OFS_SPACING = 8'h0C;
	localparam logic [7:0] OFS_RELEASE = 8'h10;
	localparam logic [7:0] OFS_SLEEP_REQUEST_PIN_ON = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	localparam logic [7:0] OFS_UPPER = 8'h20;
	localparam logic [7:0] OFS_LOWER = 8'h24;
	localparam logic [7:0] OFS_SLOT0 = 8'h40;

	// status register fields
	localparam int ST_RAIL_OK = 0;
	localparam int ST_GLOBAL_OK = 8;
	localparam int ST_SUPPLY_OK = 9;
	localparam int ST_STANDBY = 10;
	localparam int ST_FAULT = 11;
	localparam int ST_SEQ_DONE = 12;

	// interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_OK_LOST = 1;
	localparam int IRQ_SUPPLY_LOST = 2;
	localparam int IRQ_SEQ_DONE = 3;

	// reset values
	localparam logic [2:0] SPACING_RST = 3'h1;
	localparam logic [4:0] RELEASE_RST = 5'h3;
	localparam logic [5:0] SLEEP_REQUEST_PIN_ON_RST = 6'h3F;
	localparam logic [7:0] UPPER_RST = 8'h80;
	localparam logic [7:0] LOWER_RST = 8'h70;
	localparam logic [5:0] SLOT0_RST = 6'h01;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_WAIT_OK,
		SEQ_SPACE,
		SEQ_RUN,
		SEQ_FAULT
	} seq_state_t;
endpackage

// *** src/timer_if.sv ***
`timescale 1ns/10ps
// one delay timer: controller loads and starts, timer reports expiry
interface timer_if #(parameter int W = 24);
	logic start;
	logic stop;
	logic [W-1:0] count;
	logic done;
	modport ctrl (output start, output stop, output count, input done);
	modport tmr (input start, input stop, input count, output done);
endinterface

// *** src/interval_timer.sv ***
`timescale 1ns/10ps
module interval_timer #(
	parameter int W = 24
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// control
	timer_if.tmr t
);
	logic [W-1:0] cnt;
	logic busy;

	// load on start, count down, abandon on stop
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= '0;
			busy <= 1'b0;
		end
		else if (t.stop)
			busy <= 1'b0;
		else if (t.start)
		begin
			cnt <= t.count;
			busy <= 1'b1;
		end
		else if (busy)
		begin
			if (cnt == '0)
				busy <= 1'b0;
			else
				cnt <= cnt - 1'b1;
		end
	end

	// one-cycle expiry, count+1 cycles after start
	assign t.done = busy && (cnt == '0) && !t.stop && !t.start;
endmodule // interval_timer

// *** src/power_sequencer.sv ***
`timescale 1ns/10ps
// What this block does
// - sleep pin rising edge returns the device from standby to normal mode
// - wake waits 100 us deglitch, then enables all rails of the slot sequence mask together
// - sleep pin falling edge puts the device into standby mode
// - standby applies per-rail standby on/off and standby level select
// - standby entered by sleep control register write or by the sleep pin
// - over-temperature sets fault flag, drops global ok, turns rails off
// - during the fault the register port works and registers keep values
// - fault bit cleared by writing zero only once the die has cooled
// - fault cleared: return to normal mode and re-run the slot sequence
// - successive slots are separated by the slot spacing delay
// - global ok goes high at once when every rail ok bit is one and the slot sequence is done
// - reset release delay starts at supply above upper threshold
// - supply below lower threshold drops supply ok immediately
// - slot spacing is 0 to 7 ms in 1 ms steps, same for all
// - reset release delay is 5 to 160 ms in 5 ms steps
// - six slots, each may enable any set of rails
module power_sequencer #(
	parameter int MS_CYCLES = pwrseq_pkg::MS_CYC,
	parameter int RELEASE_STEP_CYCLES = pwrseq_pkg::RELEASE_STEP_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// host pin and status pins
	input wire logic sleep_request_pin,
	output logic global_power_ok_output,
	output logic supply_ok,
	// rails
	output logic [5:0] rail_enable,
	output logic [5:0] rail_standby_level,
	input wire logic [5:0] per_rail_power_ok_bits,
	// analog monitors
	input wire logic supply_above_upper,
	input wire logic supply_below_lower,
	input wire logic temp_hot,
	input wire logic temp_cooled,
	output logic [7:0] reset_upper_threshold,
	output logic [7:0] reset_lower_threshold
);
	localparam int NR = pwrseq_pkg::NUM_RAILS;
	localparam int NS = pwrseq_pkg::NUM_SLOTS;
	localparam int TW = pwrseq_pkg::TMR_W;

	pwrseq_pkg::seq_state_t state;
	logic [NR-1:0] slot_rails [NS];
	logic [2:0] slot_spacing_delay;
	logic [4:0] reset_release_delay;
	logic [NR-1:0] sleep_request_pin_on;
	logic [pwrseq_pkg::IRQ_W-1:0] irq_stat;
	logic [pwrseq_pkg::IRQ_W-1:0] irq_mask;
	logic standby;
	logic fault;
	logic [2:0] slot_idx;
	logic [NR-1:0] seq_mask;
	logic pin_q;
	logic above_q;
	logic supply_ok_q;
	logic global_ok_q;
	logic pin_rise;
	logic pin_fall;
	logic wr_sleep;
	logic fault_clear;
	logic slot_ok;
	logic seq_done;
	logic [NR-1:0] next_rail_enable;
	logic [31:0] next_rdata;

	timer_if #(.W(TW)) deglitch_t ();
	timer_if #(.W(TW)) space_t ();
	timer_if #(.W(TW)) release_t ();

	interval_timer #(.W(TW)) u_deglitch (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.t(deglitch_t)
	);
	interval_timer #(.W(TW)) u_space (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.t(space_t)
	);
	interval_timer #(.W(TW)) u_release (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.t(release_t)
	);

	// decode and edge detects
	assign pin_rise = sleep_request_pin && !pin_q;
	assign pin_fall = !sleep_request_pin && pin_q;
	assign wr_sleep = reg_wr && (reg_addr == pwrseq_pkg::OFS_SLEEP_CTRL);
	assign fault_clear = reg_wr && (reg_addr == pwrseq_pkg::OFS_FAULT)
		&& !reg_wdata[0] && temp_cooled;
	assign slot_ok = (per_rail_power_ok_bits & slot_rails[slot_idx]) == slot_rails[slot_idx];
	assign seq_done = (state == pwrseq_pkg::SEQ_RUN) || ((state == pwrseq_pkg::SEQ_WAIT_OK)
		&& slot_ok && (slot_idx == 3'(NS - 1)));

	// deglitch timer for the wake edge
	assign deglitch_t.start = pin_rise;
	assign deglitch_t.stop = !sleep_request_pin;
	assign deglitch_t.count = TW'(pwrseq_pkg::DEGLITCH_CYC - 1);

	// slot spacing timer, steps of one millisecond
	assign space_t.stop = fault;
	assign space_t.start = (state == pwrseq_pkg::SEQ_WAIT_OK) && slot_ok && !fault
		&& (slot_idx != 3'(NS - 1)) && (slot_spacing_delay != 3'h0);
	assign space_t.count = TW'(32'(slot_spacing_delay) * MS_CYCLES - 1);

	// reset release timer, (n+1) steps of five milliseconds
	assign release_t.start = supply_above_upper && !above_q;
	assign release_t.stop = supply_below_lower;
	assign release_t.count = TW'((32'(reset_release_delay) + 1) * RELEASE_STEP_CYCLES - 1);

	// input history
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_q <= 1'b1; // pin idles high, no false wake edge
			above_q <= 1'b0;
		end
		else
		begin
			pin_q <= sleep_request_pin;
			above_q <= supply_above_upper;
		end
	end

	// configuration registers, untouched by the fault
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			slot_spacing_delay <= pwrseq_pkg::SPACING_RST;
			reset_release_delay <= pwrseq_pkg::RELEASE_RST;
			sleep_request_pin_on <= pwrseq_pkg::SLEEP_REQUEST_PIN_ON_RST;
			irq_mask <= '0;
			reset_upper_threshold <= pwrseq_pkg::UPPER_RST;
			reset_lower_threshold <= pwrseq_pkg::LOWER_RST;
			for (int i = 0; i < NS; i++)
				slot_rails[i] <= NR'(pwrseq_pkg::SLOT0_RST << i);
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				pwrseq_pkg::OFS_SPACING: slot_spacing_delay <= reg_wdata[2:0];
				pwrseq_pkg::OFS_RELEASE: reset_release_delay <= reg_wdata[4:0];
				pwrseq_pkg::OFS_SLEEP_REQUEST_PIN_ON: sleep_request_pin_on <= reg_wdata[NR-1:0];
				pwrseq_pkg::OFS_IRQ_MASK: irq_mask <= reg_wdata[pwrseq_pkg::IRQ_W-1:0];
				pwrseq_pkg::OFS_UPPER: reset_upper_threshold <= reg_wdata[7:0];
				pwrseq_pkg::OFS_LOWER: reset_lower_threshold <= reg_wdata[7:0];
				default:
				begin
					for (int i = 0; i < NS; i++)
						if (reg_addr == pwrseq_pkg::OFS_SLOT0 + 8'(4 * i))
							slot_rails[i] <= reg_wdata[NR-1:0];
				end
			endcase
		end
	end

	// over-temperature fault flag, set wins over clear
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			fault <= 1'b0;
		else if (temp_hot)
			fault <= 1'b1;
		else if (fault_clear)
			fault <= 1'b0;
	end

	// operating mode: standby or normal
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			standby <= 1'b0;
		else if (fault_clear && fault)
			standby <= 1'b0;
		else if (pin_fall)
			standby <= 1'b1;
		else if (deglitch_t.done)
			standby <= 1'b0;
		else if (wr_sleep)
			standby <= reg_wdata[0];
	end

	// slot sequencer
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= pwrseq_pkg::SEQ_IDLE;
			slot_idx <= 3'h0;
			seq_mask <= '0;
		end
		else if (fault && state != pwrseq_pkg::SEQ_FAULT)
		begin
			state <= pwrseq_pkg::SEQ_FAULT;
			seq_mask <= '0;
		end
		else
		begin
			case (state)
				pwrseq_pkg::SEQ_IDLE:
				begin
					slot_idx <= 3'h0;
					seq_mask <= slot_rails[0];
					state <= pwrseq_pkg::SEQ_WAIT_OK;
				end
				pwrseq_pkg::SEQ_WAIT_OK:
				begin
					if (slot_ok)
					begin
						if (slot_idx == 3'(NS - 1))
							state <= pwrseq_pkg::SEQ_RUN;
						else if (slot_spacing_delay == 3'h0)
						begin
							slot_idx <= slot_idx + 3'h1;
							seq_mask <= seq_mask | slot_rails[slot_idx + 3'h1];
						end
						else
						begin
							slot_idx <= slot_idx + 3'h1;
							state <= pwrseq_pkg::SEQ_SPACE;
						end
					end
				end
				pwrseq_pkg::SEQ_SPACE:
				begin
					if (space_t.done)
					begin
						seq_mask <= seq_mask | slot_rails[slot_idx];
						state <= pwrseq_pkg::SEQ_WAIT_OK;
					end
				end
				pwrseq_pkg::SEQ_RUN: state <= pwrseq_pkg::SEQ_RUN;
				pwrseq_pkg::SEQ_FAULT:
				begin
					seq_mask <= '0;
					if (!fault)
						state <= pwrseq_pkg::SEQ_IDLE;
				end
				default:
					state <= pwrseq_pkg::SEQ_IDLE;
			endcase
		end
	end

	// rail enables: slot sequence mask in normal, per-rail choice in standby
	always_comb
	begin
		if (fault)
			next_rail_enable = '0;
		else if (standby)
			next_rail_enable = seq_mask & sleep_request_pin_on;
		else
			next_rail_enable = seq_mask;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rail_enable <= '0;
			rail_standby_level <= '0;
		end
		else
		begin
			rail_enable <= next_rail_enable;
			rail_standby_level <= standby ? next_rail_enable : '0;
		end
	end

	// global ok follows the rail ok bits with no added delay
	assign global_power_ok_output = (&per_rail_power_ok_bits) && seq_done && !fault;

	// supply ok: delayed rise, immediate fall
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			supply_ok_q <= 1'b0;
		else if (supply_below_lower)
			supply_ok_q <= 1'b0;
		else if (release_t.done && supply_above_upper)
			supply_ok_q <= 1'b1;
	end
	assign supply_ok = supply_ok_q && !supply_below_lower;

	// sticky interrupt status, event wins over write-one clear
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_stat <= '0;
			global_ok_q <= 1'b0;
		end
		else
		begin
			global_ok_q <= global_power_ok_output;
			for (int i = 0; i < pwrseq_pkg::IRQ_W; i++)
				if (reg_wr && reg_addr == pwrseq_pkg::OFS_IRQ_STAT && reg_wdata[i])
					irq_stat[i] <= 1'b0;
			if (temp_hot && !fault)
				irq_stat[pwrseq_pkg::IRQ_FAULT] <= 1'b1;
			if (global_ok_q && !global_power_ok_output)
				irq_stat[pwrseq_pkg::IRQ_OK_LOST] <= 1'b1;
			if (supply_ok_q && supply_below_lower)
				irq_stat[pwrseq_pkg::IRQ_SUPPLY_LOST] <= 1'b1;
			if (state == pwrseq_pkg::SEQ_WAIT_OK && slot_ok && slot_idx == 3'(NS - 1))
				irq_stat[pwrseq_pkg::IRQ_SEQ_DONE] <= 1'b1;
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// read mux
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (reg_addr)
			pwrseq_pkg::OFS_STATUS:
			begin
				next_rdata[pwrseq_pkg::ST_RAIL_OK +: NR] = per_rail_power_ok_bits;
				next_rdata[pwrseq_pkg::ST_GLOBAL_OK] = global_power_ok_output;
				next_rdata[pwrseq_pkg::ST_SUPPLY_OK] = supply_ok;
				next_rdata[pwrseq_pkg::ST_STANDBY] = standby;
				next_rdata[pwrseq_pkg::ST_FAULT] = fault;
				next_rdata[pwrseq_pkg::ST_SEQ_DONE] = seq_done;
			end
			pwrseq_pkg::OFS_SLEEP_CTRL: next_rdata[0] = standby;
			pwrseq_pkg::OFS_FAULT: next_rdata[0] = fault;
			pwrseq_pkg::OFS_SPACING: next_rdata[2:0] = slot_spacing_delay;
			pwrseq_pkg::OFS_RELEASE: next_rdata[4:0] = reset_release_delay;
			pwrseq_pkg::OFS_SLEEP_REQUEST_PIN_ON: next_rdata[NR-1:0] = sleep_request_pin_on;
			pwrseq_pkg::OFS_IRQ_STAT: next_rdata[pwrseq_pkg::IRQ_W-1:0] = irq_stat;
			pwrseq_pkg::OFS_IRQ_MASK: next_rdata[pwrseq_pkg::IRQ_W-1:0] = irq_mask;
			pwrseq_pkg::OFS_UPPER: next_rdata[7:0] = reset_upper_threshold;
			pwrseq_pkg::OFS_LOWER: next_rdata[7:0] = reset_lower_threshold;
			default:
			begin
				for (int i = 0; i < NS; i++)
					if (reg_addr == pwrseq_pkg::OFS_SLOT0 + 8'(4 * i))
						next_rdata[NR-1:0] = slot_rails[i];
			end
		endcase
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 32'h0000_0000;
	end
endmodule // power_sequencer

// *** dv/pwrseq_props.sv ***
`timescale 1ns/10ps
module pwrseq_props #(
	parameter int RELEASE_STEP_CYCLES = 20
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// register port
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// status and rails
	input wire logic global_power_ok_output,
	input wire logic supply_ok,
	input wire logic [5:0] rail_enable,
	input wire logic [5:0] rail_standby_level,
	input wire logic [5:0] per_rail_power_ok_bits,
	// monitors
	input wire logic supply_above_upper,
	input wire logic supply_below_lower,
	input wire logic temp_hot
);
	logic [15:0] up_cnt;
	// cycles the supply has stayed above the upper threshold
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			up_cnt <= 16'h0;
		else if (!supply_above_upper)
			up_cnt <= 16'h0;
		else if (up_cnt != 16'hFFFF)
			up_cnt <= up_cnt + 16'h1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_gok_rails: assert property (global_power_ok_output |-> &per_rail_power_ok_bits)
		else $error("global ok without all rails ok");
	a_hot_rails: assert property (temp_hot |-> ##2 rail_enable == 6'h00)
		else $error("rails on after fault");
	a_hot_gok: assert property (temp_hot |=> !global_power_ok_output)
		else $error("global ok during fault");
	a_hot_stay: assert property (temp_hot ##1 (temp_hot && rail_enable == 6'h00)
		|=> rail_enable == 6'h00)
		else $error("rail came on during fault");
	a_supply_fall: assert property (supply_below_lower |-> !supply_ok ##1 !supply_ok)
		else $error("supply ok while below lower");
	a_gok_hold: assert property ((global_power_ok_output && !temp_hot)
		|=> global_power_ok_output || !(&per_rail_power_ok_bits))
		else $error("global ok lost with rails ok");
	a_supply_early: assert property ($rose(supply_ok) |-> up_cnt >= RELEASE_STEP_CYCLES - 2)
		else $error("supply ok before release delay");
	a_standby_sub: assert property ((rail_standby_level & ~rail_enable) == 6'h00)
		else $error("standby level on disabled rail");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	// main scenarios
	cover property ($rose(global_power_ok_output));
	cover property ($rose(supply_ok));
	cover property ($rose(temp_hot));
endmodule // pwrseq_props

// *** dv/rail_model.sv ***
`timescale 1ns/10ps
module rail_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// rail side
	input wire logic [5:0] rail_enable,
	input wire logic slow,
	output logic [5:0] power_ok
);
	logic [5:0] ramp1;
	logic [5:0] ramp2;
	// output ramps take one cycle, two when slow
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ramp1 <= 6'h00;
			ramp2 <= 6'h00;
		end
		else
		begin
			ramp1 <= rail_enable;
			ramp2 <= ramp1 & rail_enable;
		end
	end
	// a disabled rail reads bad at once
	assign power_ok = (slow ? ramp2 : ramp1) & rail_enable;
endmodule // rail_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
	localparam int MS = 10;
	localparam int RS = 20;
	// design inputs
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep_request_pin = 1'b1;
	logic above = 1'b0;
	logic below = 1'b0;
	logic temp_hot = 1'b0;
	logic cooled = 1'b0;
	logic slow = 1'b0;
	// design outputs
	logic [31:0] reg_rdata;
	logic irq, gok, supply_ok;
	logic [5:0] rail_enable, sleep_request_pin_lvl, pok;
	logic [7:0] up_thr, lo_thr;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 32'hff2e;
	power_sequencer #(.MS_CYCLES(MS), .RELEASE_STEP_CYCLES(RS)) uut (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.sleep_request_pin(sleep_request_pin), .global_power_ok_output(gok),
		.supply_ok(supply_ok), .rail_enable(rail_enable), .rail_standby_level(sleep_request_pin_lvl),
		.per_rail_power_ok_bits(pok), .supply_above_upper(above),
		.supply_below_lower(below), .temp_hot(temp_hot), .temp_cooled(cooled),
		.reset_upper_threshold(up_thr), .reset_lower_threshold(lo_thr));
	rail_model rails (.clk_sys(clk_sys), .arst_n(arst_n), .rail_enable(rail_enable),
		.slow(slow), .power_ok(pok));
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// count cycles until the rails reach a set, checking slot gaps
	task automatic seq_watch(input logic [5:0] exp, input int sp, output int n);
		int last;
		logic [5:0] prev;
		last = -1;
		prev = rail_enable;
		n = 0;
		while (rail_enable !== exp && n < 5000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
			if (sp >= 0 && rail_enable !== prev)
			begin
				if (last >= 0)
					chk("slot gap", 1, (n - last) >= sp * MS);
				last = n;
				prev = rail_enable;
			end
		end
		chk("rails", exp, rail_enable);
	endtask
	// cycle ceiling
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			final_report();
		end
	end
	initial
	begin
		logic [31:0] v;
		logic [7:0] ra [7] = '{8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h40, 8'h30};
		logic [31:0] rv [7] = '{32'h1, 32'h3, 32'h3F, 32'h80, 32'h70, 32'h01, 32'h0};
		logic [5:0] uni;
		int sp;
		int n;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		foreach (ra[i])
		begin
			rd(ra[i], v);
			chk("reset value", rv[i], v);
		end
		chk("upper thr", 8'h80, up_thr);
		chk("lower thr", 8'h70, lo_thr);
		seq_watch(6'h3F, 1, n);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("global ok", 1, gok);
		sp = $unsigned($random(seed)) % 32;
		wr(8'h10, sp);
		above <= 1'b1;
		n = 0;
		while (supply_ok !== 1'b1 && n < 1000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("release delay", 1, n >= (sp + 1) * RS && n <= (sp + 1) * RS + 2);
		@(posedge clk_sys);
		below <= 1'b1;
		#2;
		chk("supply drop", 0, supply_ok);
		@(posedge clk_sys);
		below <= 1'b0;
		above <= 1'b0;
		wr(8'h14, 6'h05);
		wr(8'h04, 1);
		rd(8'h00, v);
		chk("standby bit", 1, v[10]);
		chk("standby rails", 6'h05, rail_enable);
		@(posedge clk_sys);
		sleep_request_pin <= 1'b0;
		repeat (10) @(posedge clk_sys);
		sleep_request_pin <= 1'b1;
		repeat (2000) @(posedge clk_sys);
		sleep_request_pin <= 1'b0;
		repeat (2500) @(posedge clk_sys);
		#1;
		chk("wake cancel", 6'h05, rail_enable);
		@(posedge clk_sys);
		sleep_request_pin <= 1'b1;
		seq_watch(6'h3F, -1, n);
		chk("deglitch", 1, n >= 4000 && n <= 4003);
		@(posedge clk_sys);
		sleep_request_pin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("sleep rails", 6'h05, rail_enable);
		chk("sleep level", 6'h05, sleep_request_pin_lvl);
		@(posedge clk_sys);
		sleep_request_pin <= 1'b1;
		seq_watch(6'h3F, -1, n);
		sp = $unsigned($random(seed)) % 8;
		wr(8'h0C, sp);
		uni = 6'h00;
		for (int k = 0; k < 6; k++)
		begin
			v = $random(seed);
			uni |= v[5:0];
			wr(8'h40 + 8'(4 * k), v[5:0]);
		end
		slow <= 1'($random(seed));
		@(posedge clk_sys);
		temp_hot <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("fault rails", 0, rail_enable);
		chk("fault ok", 0, gok);
		rd(8'h0C, v);
		chk("kept spacing", sp, v);
		@(posedge clk_sys);
		temp_hot <= 1'b0;
		wr(8'h08, 0);
		rd(8'h00, v);
		chk("fault held", 1, v[11]);
		rd(8'h18, v);
		chk("irq status", 32'hF, v);
		chk("irq masked", 0, irq);
		wr(8'h1C, 1);
		#1;
		chk("irq raised", 1, irq);
		wr(8'h18, 1);
		#1;
		chk("irq cleared", 0, irq);
		@(posedge clk_sys);
		cooled <= 1'b1;
		wr(8'h08, 0);
		seq_watch(uni, sp, n);
		rd(8'h00, v);
		chk("fault clear", 0, v[11]);
		final_report();
	end
endmodule // tb
bind power_sequencer pwrseq_props #(.RELEASE_STEP_CYCLES(RELEASE_STEP_CYCLES)) props (
	.clk_sys(clk_sys), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.global_power_ok_output(global_power_ok_output), .supply_ok(supply_ok),
	.rail_enable(rail_enable), .rail_standby_level(rail_standby_level),
	.per_rail_power_ok_bits(per_rail_power_ok_bits), .supply_above_upper(supply_above_upper),
	.supply_below_lower(supply_below_lower), .temp_hot(temp_hot));
